// ---- shared/tps_pkg.sv ----
// constants shared by the touch/proximity converter sequencer
// assumes a 40 MHz ref_clk; delays are counted in half-microsecond units
package tps_pkg;
	localparam int CLK_NS      = 25;
	localparam int HALF_US_NS  = 500;
	localparam int HALF_US_CYC = (HALF_US_NS + CLK_NS - 1) / CLK_NS;
	localparam int MS_HALF_US  = 2000;
	localparam int OSC_DIV_DEF = 8;
	localparam int HEAD_OSC    = 47;
	localparam int CONV_OSC    = 21;
	localparam int TAIL_OSC    = 1;
	localparam int DLY_MAX_NS  = 18190000;
	localparam int DLY_MAX     = DLY_MAX_NS / HALF_US_NS;
	localparam int AW          = 8;
	localparam int DW          = 32;
	localparam int SW          = 12;
	localparam int NCH         = 5;

	localparam logic [7:0] A_CTRL   = 8'h00;
	localparam logic [7:0] A_TSA    = 8'h04;
	localparam logic [7:0] A_TSC    = 8'h08;
	localparam logic [7:0] A_RATE   = 8'h0C;
	localparam logic [7:0] A_PCFG   = 8'h10;
	localparam logic [7:0] A_THR    = 8'h14;
	localparam logic [7:0] A_STAT   = 8'h18;
	localparam logic [7:0] A_MASK   = 8'h1C;
	localparam logic [7:0] A_RAW    = 8'h20;
	localparam logic [2:0] A_DATA_HI = 3'h2;

	localparam int CTRL_FILT  = 0;
	localparam int CTRL_CHM   = 2;
	localparam int CTRL_START = 8;
	localparam int CTRL_COMP  = 9;
	localparam int PCFG_SENS  = 16;
	localparam int PCFG_SHLD  = 17;
	localparam int ST_BUSY    = 8;
	localparam int ST_NEAR_F  = 9;
	localparam int ST_CPEND   = 10;

	localparam logic [1:0]  FILT_RST = 2'h0;
	localparam logic [4:0]  CHM_RST  = 5'h01;
	localparam logic [15:0] DLY_RST  = 16'h0001;
	localparam logic [11:0] THR_RST  = 12'h040;

	localparam int EV_CONV = 0;
	localparam int EV_NEAR = 1;
	localparam int EV_FAR  = 2;
	localparam int EV_COMP = 3;
	localparam int EVW     = 4;

	localparam logic [2:0] ADC_PROX = 3'h5;
	localparam logic [2:0] ADC_COMP = 3'h6;
	localparam logic [2:0] CH_NONE  = 3'h7;

	typedef enum logic [7:0] {
		ST_IDLE   = 8'h01,
		ST_HEAD   = 8'h02,
		ST_BIAS   = 8'h04,
		ST_CONV   = 8'h08,
		ST_SETTLE = 8'h10,
		ST_TAIL   = 8'h20,
		ST_PCOMP  = 8'h40,
		ST_PRAW   = 8'h80
	} tps_state_e;
endpackage

// ---- core/tps_tick_div.sv ----
// enable divider: one-cycle tick every DIV enabled cycles
// assumes en comes from logic on ref_clk
`timescale 1ns/1ps
`default_nettype none
module tps_tick_div #(
	parameter int DIV = 20
) (
	input  wire logic ref_clk,
	input  wire logic reset,
	input  wire logic en,
	output logic      tick
);
	localparam int W = $clog2(DIV + 1);
	logic [W-1:0] cnt_ff;
	logic         tick_ff;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b0;
		end else if (en && cnt_ff == W'(DIV - 1)) begin
			cnt_ff  <= '0;
			tick_ff <= 1'b1;
		end else begin
			cnt_ff  <= en ? cnt_ff + W'(1) : cnt_ff;
			tick_ff <= 1'b0;
		end
	end

	assign tick = tick_ff;
endmodule
`default_nettype wire

// ---- core/tps_chan_mem.sv ----
// per-channel result store, registered read port
// assumes one write and one read port on ref_clk
`timescale 1ns/1ps
`default_nettype none
module tps_chan_mem #(
	parameter int W  = 12,
	parameter int N  = 5,
	parameter int IW = 3
) (
	input  wire logic          ref_clk,
	input  wire logic          we,
	input  wire logic [IW-1:0] waddr,
	input  wire logic [W-1:0]  wdata,
	input  wire logic          re,
	input  wire logic [IW-1:0] raddr,
	output logic [W-1:0]       rdata
);
	logic [W-1:0] mem_ff [N];
	logic [W-1:0] q_ff;

	always_ff @(posedge ref_clk) begin
		if (we && int'(waddr) < N) begin
			mem_ff[waddr] <= wdata;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (re && int'(raddr) < N) begin
			q_ff <= mem_ff[raddr];
		end
	end

	assign rdata = q_ff;
endmodule
`default_nettype wire

// ---- core/tps_conv_seq.sv ----
// shared converter sequencer: touch runs and proximity scans
// assumes converter and register master run on ref_clk
// Summary of operation
// RULE_01: run lasts 47 osc periods plus per-channel bias, settles, 21n+1 periods
// RULE_02: samples per channel are 1, 3, 5 or 7 from filter order
// RULE_03: only channels enabled in the mask are converted, one to five
// RULE_04: bias settle delay programmable from 0.5us to about 18ms
// RULE_05: inter-sample delay programmable over the same range
// RULE_06: interrupt pin low at run end, high once all data is read
// RULE_07: host readout takes about 8 plus 16 per channel bus clocks
// RULE_08: host keeps touch rate at or below the maximum coordinate rate
// RULE_09: proximity idles and wakes each scan interval for one sample
// RULE_10: proximity front end gives 12-bit codes and drives the shield
// RULE_11: sensor select picks touchscreen top layer or external area
// RULE_12: shield select picks touchscreen bottom layer or external area
// RULE_13: proximity logic derives near/far bit and launches compensation
// RULE_14: proximity uses the same converter as the touch path
// RULE_15: converter is time-multiplexed between touch and proximity
// RULE_16: pending compensation runs first at scan start, before raw sample
// RULE_17: scan tick during a touch run waits until the run ends
`timescale 1ns/1ps
`default_nettype none
module tps_conv_seq #(
	parameter int OSC_DIV = tps_pkg::OSC_DIV_DEF
) (
	input  wire logic                    ref_clk,
	input  wire logic                    reset,
	input  wire logic [tps_pkg::AW-1:0]  reg_addr,
	input  wire logic [tps_pkg::DW-1:0]  reg_wdata,
	input  wire logic                    reg_wr,
	input  wire logic                    reg_rd,
	output logic [tps_pkg::DW-1:0]       reg_rdata,
	output logic                         host_irq_n,
	output logic                         irq,
	output logic                         adc_start,
	output logic [2:0]                   adc_chan,
	input  wire logic                    adc_done,
	input  wire logic [tps_pkg::SW-1:0]  adc_data,
	output logic                         shield_drive,
	output logic                         sensor_pin_select,
	output logic                         shield_pin_select,
	output logic                         near_far_flag
);
	import tps_pkg::*;

	tps_state_e  state_ff, nxt_state;
	logic [1:0]  filt_ff;
	logic [4:0]  chm_ff, unread_ff;
	logic [15:0] bias_ff, setl_ff, rate_ff, scan_ff;
	logic [15:0] cnt_ff, rate_cnt_ff, scan_cnt_ff, target;
	logic        sens_ff, shld_ff, near_ff;
	logic [11:0] thr_ff, raw_ff, offs_ff, diff, mem_q;
	logic [EVW-1:0] stat_ff, imask_ff, ev;
	logic [2:0]  chan_ff, samp_ff, nxt_chan, adc_chan_ff;
	logic [14:0] sum_ff;
	logic        start_pend_ff, prox_pend_ff, comp_pend_ff, praw_done_ff;
	logic        adc_start_ff, mem_sel_ff;
	logic [31:0] rdata_ff;
	logic        osc_tick, half_tick, ms_tick, unit_tick, span_end;
	logic        touch_busy, run_done, scan_hit, rate_hit, is_data_rd;

	function automatic logic [2:0] nsamp(input logic [1:0] f);
		return {f, 1'b1};
	endfunction

	function automatic logic [2:0] first_chan(input logic [4:0] m,
	                                          input logic [2:0] from);
		logic [2:0] r;
		r = CH_NONE;
		for (int i = 4; i >= 0; i--) begin
			if (m[i] && 3'(i) >= from) begin
				r = 3'(i);
			end
		end
		return r;
	endfunction

	function automatic logic [15:0] dly(input logic [15:0] v);
		if (v == 16'h0000) begin
			return 16'h0001;
		end
		return (int'(v) > DLY_MAX) ? 16'(DLY_MAX) : v;
	endfunction

	// reciprocal multiply avoids a divider for 3, 5 and 7
	function automatic logic [11:0] avg(input logic [14:0] s,
	                                    input logic [1:0] f);
		logic [15:0] k;
		logic [30:0] p;
		case (f)
			2'h0:    k = 16'h8000;
			2'h1:    k = 16'h2AAB;
			2'h2:    k = 16'h199A;
			default: k = 16'h124A;
		endcase
		p = 31'(s) * 31'(k);
		return p[26:15];
	endfunction

	tps_tick_div #(.DIV(OSC_DIV)) u_osc (
		.ref_clk (ref_clk),
		.reset   (reset),
		.en      (1'b1),
		.tick    (osc_tick)
	);
	tps_tick_div #(.DIV(HALF_US_CYC)) u_half (
		.ref_clk (ref_clk),
		.reset   (reset),
		.en      (1'b1),
		.tick    (half_tick)
	);
	tps_tick_div #(.DIV(MS_HALF_US)) u_ms (
		.ref_clk (ref_clk),
		.reset   (reset),
		.en      (half_tick),
		.tick    (ms_tick)
	);

	assign touch_busy = state_ff inside {ST_HEAD, ST_BIAS, ST_CONV,
	                                     ST_SETTLE, ST_TAIL};
	assign unit_tick = (state_ff inside {ST_HEAD, ST_CONV, ST_TAIL})
	                   ? osc_tick : half_tick;
	assign nxt_chan = first_chan(chm_ff, chan_ff + 3'h1);

	always_comb begin
		case (state_ff)
			ST_HEAD:   target = 16'(HEAD_OSC);
			ST_BIAS:   target = dly(bias_ff);     // RULE_04
			ST_CONV:   target = 16'(CONV_OSC);
			ST_SETTLE: target = dly(setl_ff);     // RULE_05
			ST_TAIL:   target = 16'(TAIL_OSC);
			default:   target = 16'h0001;
		endcase
	end
	assign span_end = unit_tick && cnt_ff == target - 16'h0001;
	assign run_done = state_ff == ST_TAIL && span_end && nxt_chan == CH_NONE;

	// proximity served first from idle; a touch run is never cut short
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE:
				if (prox_pend_ff) begin
					nxt_state = comp_pend_ff ? ST_PCOMP : ST_PRAW; // RULE_16
				end else if (start_pend_ff) begin
					nxt_state = ST_HEAD;
				end
			ST_HEAD:
				if (span_end) nxt_state = ST_BIAS;      // RULE_01
			ST_BIAS:
				if (span_end) nxt_state = ST_CONV;
			ST_CONV:
				if (span_end) begin
					nxt_state = (samp_ff + 3'h1 < nsamp(filt_ff)) // RULE_02
					            ? ST_SETTLE : ST_TAIL;
				end
			ST_SETTLE:
				if (span_end) nxt_state = ST_CONV;
			ST_TAIL:
				if (span_end) begin
					nxt_state = (nxt_chan == CH_NONE) ? ST_IDLE : ST_BIAS;
				end
			ST_PCOMP:
				if (adc_done) nxt_state = ST_PRAW;
			ST_PRAW:
				if (adc_done) nxt_state = ST_IDLE;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			state_ff <= ST_IDLE;
			cnt_ff   <= 16'h0000;
		end else begin
			state_ff <= nxt_state;
			cnt_ff   <= (nxt_state != state_ff) ? 16'h0000
			          : unit_tick ? cnt_ff + 16'h0001 : cnt_ff;
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			chan_ff <= 3'h0;
			samp_ff <= 3'h0;
			sum_ff  <= 15'h0000;
		end else begin
			if (state_ff == ST_IDLE && nxt_state == ST_HEAD) begin
				chan_ff <= first_chan(chm_ff, 3'h0);  // RULE_03
			end else if (state_ff == ST_TAIL && span_end) begin
				chan_ff <= nxt_chan;                   // RULE_03
			end
			if (state_ff == ST_BIAS) begin
				samp_ff <= 3'h0;
				sum_ff  <= 15'h0000;
			end else if (state_ff == ST_CONV) begin
				if (span_end) samp_ff <= samp_ff + 3'h1;
				if (adc_done) sum_ff <= sum_ff + 15'(adc_data);
			end
		end
	end

	// one converter, one owner at a time
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			adc_start_ff <= 1'b0;
			adc_chan_ff  <= 3'h0;
		end else begin
			adc_start_ff <= nxt_state != state_ff && // RULE_14 RULE_15
			                nxt_state inside {ST_CONV, ST_PCOMP, ST_PRAW};
			adc_chan_ff  <= (nxt_state == ST_PCOMP) ? ADC_COMP
			              : (nxt_state == ST_PRAW) ? ADC_PROX : chan_ff;
		end
	end

	tps_chan_mem #(.W(SW), .N(NCH), .IW(3)) u_mem (
		.ref_clk (ref_clk),
		.we      (state_ff == ST_TAIL && span_end),
		.waddr   (chan_ff),
		.wdata   (avg(sum_ff, filt_ff)),
		.re      (is_data_rd),
		.raddr   (reg_addr[4:2]),
		.rdata   (mem_q)
	);

	assign is_data_rd = reg_rd && reg_addr[7:5] == A_DATA_HI &&
	                    reg_addr[1:0] == 2'h0 && int'(reg_addr[4:2]) < NCH;

	// blocked while data is unread, so a late host costs a tick, not data
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			unread_ff     <= 5'h00;
			start_pend_ff <= 1'b0;
			rate_cnt_ff   <= 16'h0000;
		end else begin
			if (run_done) begin
				unread_ff <= chm_ff;                  // RULE_06
			end else if (is_data_rd) begin
				unread_ff <= unread_ff & ~(5'h01 << reg_addr[4:2]); // RULE_06
			end
			if (rate_ff == 16'h0000 || rate_hit) begin
				rate_cnt_ff <= 16'h0000;
			end else if (half_tick) begin
				rate_cnt_ff <= rate_cnt_ff + 16'h0001;
			end
			if (state_ff == ST_IDLE && nxt_state == ST_HEAD) begin
				start_pend_ff <= 1'b0;
			end else if ((rate_hit || (reg_wr && reg_addr == A_CTRL &&
			              reg_wdata[CTRL_START])) && !touch_busy &&
			             unread_ff == 5'h00 && chm_ff != 5'h00) begin
				start_pend_ff <= 1'b1;
			end
		end
	end
	assign rate_hit = rate_ff != 16'h0000 && half_tick &&
	                  rate_cnt_ff == rate_ff - 16'h0001;
	assign host_irq_n = ~(|unread_ff);

	assign scan_hit = scan_ff != 16'h0000 && ms_tick &&
	                  scan_cnt_ff == scan_ff - 16'h0001;
	assign diff = (raw_ff > offs_ff) ? raw_ff - offs_ff : 12'h000;

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			scan_cnt_ff  <= 16'h0000;
			prox_pend_ff <= 1'b0;
			comp_pend_ff <= 1'b0;
			raw_ff       <= 12'h000;
			offs_ff      <= 12'h000;
			near_ff      <= 1'b0;
			praw_done_ff <= 1'b0;
		end else begin
			if (scan_ff == 16'h0000 || scan_hit) begin
				scan_cnt_ff <= 16'h0000;
			end else if (ms_tick) begin
				scan_cnt_ff <= scan_cnt_ff + 16'h0001;
			end
			if (scan_hit) begin
				prox_pend_ff <= 1'b1;                 // RULE_09 RULE_17
			end else if (state_ff == ST_IDLE && !(nxt_state inside
			             {ST_IDLE, ST_HEAD})) begin
				prox_pend_ff <= 1'b0;
			end
			if ((reg_wr && reg_addr == A_CTRL && reg_wdata[CTRL_COMP]) ||
			    (reg_wr && reg_addr == A_PCFG && scan_ff == 16'h0000 &&
			     reg_wdata[15:0] != 16'h0000)) begin
				comp_pend_ff <= 1'b1;                 // RULE_13
			end else if (state_ff == ST_PCOMP && adc_done) begin
				comp_pend_ff <= 1'b0;
			end
			if (state_ff == ST_PCOMP && adc_done) offs_ff <= adc_data;
			if (state_ff == ST_PRAW && adc_done) raw_ff <= adc_data; // RULE_10
			// raw_ff lands one cycle before the compare reads it
			praw_done_ff <= state_ff == ST_PRAW && adc_done;
			if (praw_done_ff) begin
				near_ff <= diff >= thr_ff;            // RULE_13
			end
		end
	end

	always_comb begin
		ev          = '0;
		ev[EV_CONV] = run_done;
		ev[EV_COMP] = state_ff == ST_PCOMP && adc_done;
		ev[EV_NEAR] = praw_done_ff && diff >= thr_ff && !near_ff;
		ev[EV_FAR]  = praw_done_ff && diff < thr_ff && near_ff;
	end

	// status clears by write-one, a same-cycle event survives
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			stat_ff <= '0;
		end else begin
			stat_ff <= (stat_ff & ~((reg_wr && reg_addr == A_STAT)
			           ? reg_wdata[EVW-1:0] : '0)) | ev;
		end
	end
	assign irq = |(stat_ff & imask_ff);

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			filt_ff  <= FILT_RST;
			chm_ff   <= CHM_RST;
			bias_ff  <= DLY_RST;
			setl_ff  <= DLY_RST;
			rate_ff  <= 16'h0000;
			scan_ff  <= 16'h0000;
			sens_ff  <= 1'b0;
			shld_ff  <= 1'b0;
			thr_ff   <= THR_RST;
			imask_ff <= '0;
		end else if (reg_wr) begin
			case (reg_addr)
				A_CTRL: begin
					filt_ff <= reg_wdata[CTRL_FILT +: 2];
					chm_ff  <= reg_wdata[CTRL_CHM +: 5];
				end
				A_TSA:  bias_ff  <= reg_wdata[15:0];
				A_TSC:  setl_ff  <= reg_wdata[15:0];
				A_RATE: rate_ff  <= reg_wdata[15:0];
				A_PCFG: begin
					scan_ff <= reg_wdata[15:0];
					sens_ff <= reg_wdata[PCFG_SENS];   // RULE_11
					shld_ff <= reg_wdata[PCFG_SHLD];   // RULE_12
				end
				A_THR:  thr_ff   <= reg_wdata[11:0];
				A_MASK: imask_ff <= reg_wdata[EVW-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdata_ff   <= 32'h0;
			mem_sel_ff <= 1'b0;
		end else begin
			mem_sel_ff <= is_data_rd;
			rdata_ff   <= 32'h0;
			if (reg_rd) begin
				case (reg_addr)
					A_CTRL: rdata_ff <= 32'({chm_ff, filt_ff});
					A_TSA:  rdata_ff <= 32'(bias_ff);
					A_TSC:  rdata_ff <= 32'(setl_ff);
					A_RATE: rdata_ff <= 32'(rate_ff);
					A_PCFG: rdata_ff <= 32'({shld_ff, sens_ff, scan_ff});
					A_THR:  rdata_ff <= 32'(thr_ff);
					A_STAT: rdata_ff <= 32'({comp_pend_ff, near_ff,
					                       touch_busy, 4'h0, stat_ff});
					A_MASK: rdata_ff <= 32'(imask_ff);
					A_RAW:  rdata_ff <= 32'(raw_ff);
					default: rdata_ff <= 32'h0;
				endcase
			end
		end
	end
	assign reg_rdata = mem_sel_ff ? 32'(mem_q) : rdata_ff;

	assign adc_start         = adc_start_ff;
	assign adc_chan          = adc_chan_ff;
	assign shield_drive      = state_ff inside {ST_PCOMP, ST_PRAW}; // RULE_10
	assign sensor_pin_select = sens_ff;
	assign shield_pin_select = shld_ff;
	assign near_far_flag     = near_ff;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	property p_head_len;
		($past(state_ff) == ST_HEAD && state_ff == ST_BIAS)
		|-> $past(cnt_ff) == 16'(HEAD_OSC - 1);
	endproperty
	a_head_len: assert property (p_head_len) // RULE_01
		else $error("header span not 47 periods");
	property p_samples;
		state_ff == ST_TAIL |-> samp_ff == nsamp(filt_ff);
	endproperty
	a_samples: assert property (p_samples) // RULE_02
		else $error("wrong sample count");
	property p_chan_on;
		state_ff == ST_BIAS |-> chm_ff[chan_ff];
	endproperty
	a_chan_on: assert property (p_chan_on) // RULE_03
		else $error("disabled channel converted");
	property p_bias;
		($past(state_ff) == ST_BIAS && state_ff == ST_CONV)
		|-> $past(cnt_ff) == $past(dly(bias_ff)) - 16'h0001;
	endproperty
	a_bias: assert property (p_bias) // RULE_04
		else $error("bias settle length wrong");
	property p_settle;
		($past(state_ff) == ST_SETTLE && state_ff == ST_CONV)
		|-> $past(cnt_ff) == $past(dly(setl_ff)) - 16'h0001;
	endproperty
	a_settle: assert property (p_settle) // RULE_05
		else $error("inter-sample length wrong");
	property p_irq;
		run_done |=> !host_irq_n;
	endproperty
	a_irq: assert property (p_irq) // RULE_06
		else $error("interrupt not raised at run end");
	property p_scan;
		scan_hit |=> prox_pend_ff || shield_drive;
	endproperty
	a_scan: assert property (p_scan) // RULE_09
		else $error("scan tick lost");
	property p_share;
		shield_drive |-> !touch_busy;
	endproperty
	a_share: assert property (p_share) // RULE_15
		else $error("converter owned twice");
	property p_comp_first;
		($past(state_ff) == ST_IDLE && state_ff == ST_PRAW)
		|-> !$past(comp_pend_ff);
	endproperty
	a_comp_first: assert property (p_comp_first) // RULE_16
		else $error("raw sample before pending compensation");
	property p_wait;
		(prox_pend_ff && touch_busy && !run_done) |=> !shield_drive;
	endproperty
	a_wait: assert property (p_wait) // RULE_17
		else $error("proximity cut into touch run");
endmodule
`default_nettype wire

// ---- verif/tps_adc_model.sv ----
// behavioural shared converter answering the sequencer's start pulses
// assumes starts are single-cycle pulses on ref_clk
`timescale 1ns/1ps
`default_nettype none
module tps_adc_model #(
	parameter int TLAT = 3,
	parameter int PLAT = 30
) (
	input  wire logic        ref_clk,
	input  wire logic        reset,
	input  wire logic        adc_start,
	input  wire logic [2:0]  adc_chan,
	output logic             adc_done,
	output logic [11:0]      adc_data
);
	logic [7:0] cnt_ff;
	logic       busy_ff;
	logic [2:0] ch_ff;
	// one converter serves both paths, one job at a time
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			cnt_ff   <= 8'h00;
			busy_ff  <= 1'b0;
			ch_ff    <= 3'h0;
			adc_done <= 1'b0;
			adc_data <= 12'hA5A;
		end else begin
			adc_done <= 1'b0;
			// data toggle outside done so stale codes never look valid
			adc_data <= ~adc_data;
			if (adc_start) begin
				busy_ff <= 1'b1;
				ch_ff   <= adc_chan;
				cnt_ff  <= (adc_chan >= 3'h5) ? 8'(PLAT) : 8'(TLAT);
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff - 8'h01;
				if (cnt_ff == 8'h01) begin
					busy_ff  <= 1'b0;
					adc_done <= 1'b1;
					adc_data <= (ch_ff == 3'h6) ? 12'h100 :
						(ch_ff == 3'h5) ? 12'h200 : {9'h024, ch_ff};
				end
			end
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench for the converter sequencer
// assumes the converter model above and a prompt register host
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tps_pkg::*;
	localparam int OD = 2;
	logic        ref_clk = 1'b0;
	logic        reset = 1'b1;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic        host_irq_n, irq, adc_start, adc_done, shield_drive;
	logic        sensor_pin_select, shield_pin_select, near_far_flag;
	logic [2:0]  adc_chan;
	logic [11:0] adc_data;
	logic [31:0] v;
	logic [2:0]  tlog[$];
	logic [2:0]  plog[$];
	int          fail_count = 0, compares = 0, starts = 0, c, e, i, f, lo;
	int          prox_in_run = 0, bad_shield = 0;
	bit          in_run = 0;
	always #12.5 ref_clk = ~ref_clk;
	tps_conv_seq #(.OSC_DIV(OD)) i_dut (.ref_clk(ref_clk), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_irq_n(host_irq_n),
		.irq(irq), .adc_start(adc_start), .adc_chan(adc_chan),
		.adc_done(adc_done), .adc_data(adc_data),
		.shield_drive(shield_drive), .sensor_pin_select(sensor_pin_select),
		.shield_pin_select(shield_pin_select),
		.near_far_flag(near_far_flag));
	tps_adc_model i_adc (.ref_clk(ref_clk), .reset(reset),
		.adc_start(adc_start), .adc_chan(adc_chan), .adc_done(adc_done),
		.adc_data(adc_data));
	always @(posedge ref_clk) begin
		if (adc_start === 1'b1) begin
			starts++;
			if (adc_chan >= 3'h5) begin
				plog.push_back(adc_chan);
				if (in_run) prox_in_run++;
			end else tlog.push_back(adc_chan);
		end
		if (adc_done === 1'b1 && shield_drive !== (adc_chan >= 3'h5))
			bad_shield++;
	end
	task automatic stop_test;
		$display("checks %0d mismatches %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// free-running ticks: each span may end up to one unit early
	function automatic int lo_cyc(input int nom, input int no,
	                              input int nh);
		return nom - no * (OD - 1) - nh * (HALF_US_CYC - 1) - 1;
	endfunction
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		@(posedge ref_clk);
		#1;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
		@(posedge ref_clk);
		#1;
	endtask
	// start a run and count cycles until the interrupt pin falls
	task automatic run_touch(input logic [31:0] ctrl, output int cyc);
		int k;
		starts = 0;
		tlog.delete();
		in_run = 1;
		wr(A_CTRL, ctrl | 32'h100);
		for (k = 0; k < 70000; k++) begin
			@(posedge ref_clk);
			#1;
			if (host_irq_n === 1'b0) break;
		end
		in_run = 0;
		cyc = k;
		if (k == 70000) begin
			fail_count++;
			stop_test;
		end
	endtask
	initial begin
		repeat (99000) @(posedge ref_clk);
		fail_count++;
		stop_test;
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		reset <= 1'b0;
		@(posedge ref_clk);
		#1;
		rd(A_CTRL, v); chk(v, 32'h4);
		rd(A_THR, v); chk(v, 32'h40);
		rd(A_TSA, v); chk(v, 32'h1);
		chk(host_irq_n, 1'b1);
		chk(irq, 1'b0);
		rd(8'h3C, v); chk(v, 32'h0);
		$display("reset test done");
		wr(A_TSA, 32'h3);
		wr(A_TSC, 32'h2);
		run_touch(32'h15, c);
		e = (HEAD_OSC + 2 * (CONV_OSC * 3 + 1)) * OD;
		e = e + 2 * (3 + 2 * 2) * HALF_US_CYC;
		lo = lo_cyc(e, 9, 6);
		chk(32'(c >= lo && c < e), 1);
		chk(32'(starts), 6);
		chk(tlog[0], 3'h0);
		chk(tlog[5], 3'h2);
		rd(A_STAT, v); chk(v[0], 1'b1);
		wr(A_MASK, 32'h1); chk(irq, 1'b1);
		wr(A_MASK, 32'h0); chk(irq, 1'b0);
		wr(A_MASK, 32'h1);
		wr(A_STAT, 32'h1); chk(irq, 1'b0);
		// host reads promptly, well inside the coordinate rate
		rd(8'h40, v); chk(host_irq_n, 1'b0);
		chk(v, 32'h120);
		rd(8'h48, v); chk(host_irq_n, 1'b1);
		chk(v, 32'h122);
		$display("timing and interrupt test done");
		for (f = 0; f < 4; f++) begin
			run_touch(32'h4 | 32'(f), c);
			chk(32'(starts), 32'(2 * f + 1));
			e = (HEAD_OSC + CONV_OSC * (2 * f + 1) + 1) * OD;
			e = e + (3 + 2 * f * 2) * HALF_US_CYC;
			lo = lo_cyc(e, 2 * f + 3, 2 * f + 1);
			chk(32'(c >= lo && c < e), 1);
			rd(8'h40, v); chk(host_irq_n, 1'b1);
			chk(v, 32'h120);
		end
		$display("filter test done");
		wr(A_PCFG, 32'h30001);
		chk(sensor_pin_select, 1'b1);
		chk(shield_pin_select, 1'b1);
		// long bias so the first scan tick lands inside the run
		wr(A_TSA, 32'd2400);
		run_touch(32'h4, c);
		chk(32'(prox_in_run), 0);
		rd(8'h40, v); chk(v, 32'h120);
		for (i = 0; i < 3000; i++) begin
			@(posedge ref_clk);
			#1;
			if (near_far_flag === 1'b1) break;
		end
		chk(near_far_flag, 1'b1);
		chk(32'(plog.size()), 2);
		chk(plog[0], ADC_COMP);
		chk(plog[1], ADC_PROX);
		rd(A_RAW, v); chk(v, 32'h200);
		chk(32'(bad_shield), 0);
		rd(A_STAT, v);
		chk(v[EV_NEAR], 1'b1);
		chk(v[EV_COMP], 1'b1);
		chk(v[ST_CPEND], 1'b0);
		$display("proximity test done");
		// paced runs: ticks are dropped while results sit unread
		wr(A_TSA, 32'h3);
		starts = 0;
		wr(A_RATE, 32'h10);
		for (i = 0; i < 2000; i++) begin
			@(posedge ref_clk);
			#1;
			if (host_irq_n === 1'b0) break;
		end
		repeat (1000) @(posedge ref_clk);
		#1;
		chk(host_irq_n, 1'b0);
		chk(32'(starts), 1);
		wr(A_RATE, 32'h0);
		rd(8'h40, v); chk(v, 32'h120);
		chk(host_irq_n, 1'b1);
		$display("rate test done");
		stop_test;
	end
endmodule
`default_nettype wire
